// [logic/rbc_top.sv]
// chip reset combiner, wake-up timer and two-stage brownout supervisor
// assumes analog comparators and power-on detector deliver asynchronous levels
// Notes on behaviour
// - chip reset merges pin, watchdog, power-on and brownout causes only
// - any cause drives status pin low and restarts the wake-up timer
// - reset held until pin released, oscillator up, count done, flash ready
// - status pin goes high at release, or when supply recovers from a brownout-only reset
// - at release the processor fetches from address zero, the boot vector
// - every register sits at its reset value while sys_rst is asserted
// - first brownout stage raises an interrupt request below 2.2 V
// - interrupt reaches cpu only when enabled; status always readable
// - second brownout stage forces chip reset below 1.85 V
// - brownout holds reset down to about 1 V, then power-on takes over
// - both brownout stages have hysteresis so the indication stays stable
`timescale 1ns/10ps
`include "rbc_map.svh"
module rbc_top #(
   parameter int CNT_W = 13,
   parameter logic [CNT_W-1:0] WAKE_CLKS = CNT_W'(`RBC_WAKE_CLKS),
   parameter logic [CNT_W-1:0] HYST_CLKS = CNT_W'(`RBC_HYST_CYC)
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic ext_reset_n,
   input wire logic wdt_timeout,
   input wire logic por_active,
   input wire logic brownout_stage1_cmp,
   input wire logic brownout_stage2_cmp,
   input wire logic osc_ready,
   input wire logic flash_init_done,
   input wire logic brownout_irq_enable,
   output logic chip_reset_q,
   output logic reset_status_out,
   output logic cpu_start_q,
   output logic [31:0] boot_addr_q,
   output logic brownout_irq_q,
   output logic brownout_status_q,
   output logic cpu_irq_q,
   output rbc_pkg::rbc_cause_t reset_cause_q
);
   import rbc_pkg::*;

   logic [4:0] sync_s;
   logic ext_n_s;
   logic por_s;
   logic bo1_s;
   logic bo2_s;
   logic osc_s;

   rbc_sync #(
      .WIDTH(5),
      .RST_VAL(`RBC_SYNC_RST)
   ) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in({osc_ready, brownout_stage2_cmp, brownout_stage1_cmp, por_active, ext_reset_n}),
      .sync_out(sync_s)
   );

   assign ext_n_s = sync_s[0];
   assign por_s = sync_s[1];
   assign bo1_s = sync_s[2];
   assign bo2_s = sync_s[3];
   assign osc_s = sync_s[4];

   // hysteresis: a stage trips at once, clears only after a quiet spell
   function automatic logic [CNT_W-1:0] hyst_cnt(input logic cmp, input logic [CNT_W-1:0] c);
      if (cmp) begin
         hyst_cnt = '0;
      end else if (c != HYST_CLKS) begin
         hyst_cnt = c + CNT_W'(1);
      end else begin
         hyst_cnt = c;
      end
   endfunction : hyst_cnt

   logic bo1_flag_q, bo1_flag_d;
   logic bo2_flag_q, bo2_flag_d;
   logic [CNT_W-1:0] h1_q, h1_d, h2_q, h2_d;

   always_comb begin
      h1_d = hyst_cnt(bo1_s, h1_q);
      h2_d = hyst_cnt(bo2_s, h2_q);
      bo1_flag_d = bo1_s || (bo1_flag_q && h1_d != HYST_CLKS);
      bo2_flag_d = bo2_s || (bo2_flag_q && h2_d != HYST_CLKS);
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         h1_q <= '0;
         h2_q <= '0;
         bo1_flag_q <= 1'b1;
         bo2_flag_q <= 1'b1;
      end else begin
         h1_q <= h1_d;
         h2_q <= h2_d;
         bo1_flag_q <= bo1_flag_d;
         bo2_flag_q <= bo2_flag_d;
      end
   end

   // interrupt path toward the interrupt controller
   logic bo_irq_d, bo_status_d, cpu_irq_d;

   always_comb begin
      bo_irq_d = bo1_flag_d;
      bo_status_d = bo1_flag_d;
      cpu_irq_d = bo1_flag_d && brownout_irq_enable;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         brownout_irq_q <= 1'b0;
         brownout_status_q <= 1'b0;
         cpu_irq_q <= 1'b0;
      end else begin
         brownout_irq_q <= bo_irq_d;
         brownout_status_q <= bo_status_d;
         cpu_irq_q <= cpu_irq_d;
      end
   end

   // reset sequencer
   rbc_cause_t cause_now;
   rbc_cause_t cause_d;
   rbc_state_t state_q, state_d;
   logic [CNT_W-1:0] wake_q, wake_d;
   logic any_cause;
   logic chip_reset_d, rso_d, cpu_start_d;
   logic [31:0] boot_addr_d;

   always_comb begin
      cause_now = '0;
      cause_now[`RBC_CAUSE_EXT] = !ext_n_s;
      cause_now[`RBC_CAUSE_WDT] = wdt_timeout;
      // below the brownout floor the power-on detector keeps reset
      cause_now[`RBC_CAUSE_POR] = por_s;
      cause_now[`RBC_CAUSE_BROWN] = bo2_flag_d;
      any_cause = |cause_now;
   end

   always_comb begin
      state_d = state_q;
      wake_d = wake_q;
      cause_d = reset_cause_q;
      case (state_q)
         RBC_ST_HOLD: begin
            wake_d = '0;
            cause_d = reset_cause_q | cause_now; // set wins while held
            if (!any_cause) begin
               state_d = RBC_ST_WAKE;
            end
         end
         RBC_ST_WAKE: begin
            cause_d = reset_cause_q | cause_now;
            if (any_cause) begin
               state_d = RBC_ST_HOLD;
               wake_d = '0;
            end else if (osc_s && wake_q != WAKE_CLKS) begin
               wake_d = wake_q + CNT_W'(1);
            end else if (osc_s && flash_init_done) begin
               state_d = RBC_ST_RUN;
            end
         end
         RBC_ST_RUN: begin
            if (any_cause) begin
               state_d = RBC_ST_HOLD;
               wake_d = '0;
               cause_d = cause_now; // new episode replaces old cause
            end
         end
         default: begin
            state_d = RBC_ST_HOLD;
            wake_d = '0;
         end
      endcase
      chip_reset_d = (state_d != RBC_ST_RUN);
      // brownout-only episode: pin follows the supply, not the timer
      rso_d = (state_d == RBC_ST_RUN) ||
              (state_d == RBC_ST_WAKE && cause_d == rbc_cause_t'(1 << `RBC_CAUSE_BROWN));
      cpu_start_d = (state_d == RBC_ST_RUN) && (state_q != RBC_ST_RUN);
      boot_addr_d = `RBC_BOOT_VECTOR;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= RBC_ST_HOLD;
         wake_q <= '0;
         reset_cause_q <= rbc_cause_t'(1 << `RBC_CAUSE_POR);
         chip_reset_q <= 1'b1;
         reset_status_out <= 1'b0;
         cpu_start_q <= 1'b0;
         boot_addr_q <= `RBC_BOOT_VECTOR;
      end else begin
         state_q <= state_d;
         wake_q <= wake_d;
         reset_cause_q <= cause_d;
         chip_reset_q <= chip_reset_d;
         reset_status_out <= rso_d;
         cpu_start_q <= cpu_start_d;
         boot_addr_q <= boot_addr_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   cause_to_reset_a: assert property (any_cause |=> chip_reset_q)
      else $error("reset cause did not assert chip reset");
   cause_pin_low_a: assert property (any_cause |=> !reset_status_out ##0 wake_q == '0)
      else $error("status pin not low or timer not restarted");
   pin_hold_a: assert property (!ext_n_s |=> chip_reset_q)
      else $error("chip reset released with pin asserted");
   release_cond_a: assert property ($fell(chip_reset_q) |->
      $past(wake_q) == WAKE_CLKS && $past(flash_init_done) && $past(osc_s))
      else $error("release before timer, oscillator or flash ready");
   release_pin_high_a: assert property ($fell(chip_reset_q) |-> reset_status_out)
      else $error("status pin not high at release");
   boot_fetch_a: assert property (cpu_start_q |->
      !chip_reset_q && boot_addr_q == 32'h0 ##1 !cpu_start_q)
      else $error("start pulse without boot vector or longer than one cycle");
   stage1_irq_a: assert property (bo1_s |=> brownout_irq_q && brownout_status_q)
      else $error("stage one brownout not flagged");
   irq_gate_a: assert property (cpu_irq_q |-> brownout_irq_q && $past(brownout_irq_enable))
      else $error("cpu interrupt without enable");
   stage2_reset_a: assert property (bo2_s |=> chip_reset_q && !reset_status_out)
      else $error("stage two brownout did not force reset");
   hyst_quiet_a: assert property ($fell(brownout_irq_q) |->
      !$past(bo1_s, 1) && !$past(bo1_s, 2) && !$past(bo1_s, 3))
      else $error("stage one indication dropped without quiet spell");
endmodule : rbc_top

// [logic/rbc_map.svh]
// offsets-free constant map for the reset and brownout controller
// assumes inclusion by bare name from the package and the top module
`ifndef RBC_MAP_SVH
`define RBC_MAP_SVH

`define RBC_CLK_MHZ 40
// supervisor trip points, millivolts, kept for reference by the analog side
`define RBC_BO1_MV 2200
`define RBC_BO2_MV 1850
`define RBC_POR_TAKEOVER_MV 1000
// fixed clock count of the wake-up timer
`define RBC_WAKE_CLKS 4096
// digital hysteresis hold on the comparators, microseconds
`define RBC_HYST_US 10
`define RBC_HYST_CYC (`RBC_HYST_US * `RBC_CLK_MHZ)
`define RBC_BOOT_VECTOR 32'h0000_0000
// reset cause bit positions
`define RBC_CAUSE_EXT 0
`define RBC_CAUSE_WDT 1
`define RBC_CAUSE_POR 2
`define RBC_CAUSE_BROWN 3
`define RBC_NUM_CAUSES 4
// synchroniser reset values: ext_n, por, stage one, stage two, osc_ready
`define RBC_SYNC_RST 5'h0E

`endif

// [logic/rbc_pkg.sv]
// types shared by the reset and brownout controller
// assumes rbc_map.svh is on the include path
package rbc_pkg;
`include "rbc_map.svh"

   typedef enum logic [2:0] {
      RBC_ST_HOLD = 3'b001,
      RBC_ST_WAKE = 3'b010,
      RBC_ST_RUN  = 3'b100
   } rbc_state_t;

   typedef logic [`RBC_NUM_CAUSES-1:0] rbc_cause_t;

endpackage : rbc_pkg

// [logic/rbc_sync.sv]
// two-flop level synchroniser, one lane per bit
// assumes inputs are asynchronous levels; each lane has its own reset value
`timescale 1ns/10ps
module rbc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : rbc_sync

// [verification/rbc_far_side.sv]
// far side of the reset controller: board reset switch and interrupt controller
// assumes the bench drives press on the rising clock edge
`timescale 1ns/10ps
module rbc_far_side (
   input wire logic ref_clk,
   input wire logic press,
   input wire logic cpu_irq_q,
   output logic ext_reset_n,
   output logic irq_taken
);
   // board pull-up: pin low only while the switch is held
   assign ext_reset_n = !press;
   // controller samples the request one edge late, as a real latch would
   always_ff @(posedge ref_clk) begin
      irq_taken <= cpu_irq_q;
   end
endmodule : rbc_far_side

// [verification/tb_reset_brownout_control.sv]
// self-checking bench for the reset combiner and brownout supervisor
// assumes rbc_pkg compiled first; wake count shortened to 8, hold to 4
`timescale 1ns/10ps
module tb_reset_brownout_control;
   import rbc_pkg::*;
   localparam int WK = 8;
   logic ref_clk, sys_rst, press, wdt, por, b1, b2, osc, flash, irq_en;
   logic ext_n, irq_taken, chip_reset_q, reset_status_out, cpu_start_q;
   logic brownout_irq_q, brownout_status_q, cpu_irq_q;
   logic [31:0] boot_addr_q;
   rbc_cause_t reset_cause_q;
   int n_mismatch = 0;
   int checks_done = 0;

   rbc_top #(.CNT_W(13), .WAKE_CLKS(13'h008), .HYST_CLKS(13'h004)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .ext_reset_n(ext_n), .wdt_timeout(wdt),
      .por_active(por), .brownout_stage1_cmp(b1), .brownout_stage2_cmp(b2),
      .osc_ready(osc), .flash_init_done(flash), .brownout_irq_enable(irq_en),
      .chip_reset_q(chip_reset_q), .reset_status_out(reset_status_out),
      .cpu_start_q(cpu_start_q), .boot_addr_q(boot_addr_q),
      .brownout_irq_q(brownout_irq_q), .brownout_status_q(brownout_status_q),
      .cpu_irq_q(cpu_irq_q), .reset_cause_q(reset_cause_q));
   rbc_far_side far (.ref_clk(ref_clk), .press(press), .cpu_irq_q(cpu_irq_q),
      .ext_reset_n(ext_n), .irq_taken(irq_taken));

   initial begin
      ref_clk = 0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // lo: fewest edges the hold may last, given the wake count
   task automatic wait_release(input int lo);
      int n;
      n = 0;
      while (chip_reset_q !== 1'b0 && n < 60) begin
         tick(1);
         n++;
      end
      chk("release_min", n >= lo, 1);
      chk("release_max", n < 60, 1);
      chk("status_high", reset_status_out, 1);
      chk("cpu_start", cpu_start_q, 1);
      chk("boot_addr", boot_addr_q, 0);
      chk("irq_reset", cpu_irq_q, 0);
      tick(1);
      chk("start_pulse", cpu_start_q, 0);
   endtask : wait_release

   task automatic t_cause(input int idx);
      @(posedge ref_clk);
      case (idx)
         0: press <= 1;
         1: wdt <= 1;
         2: por <= 1;
         default: b2 <= 1;
      endcase
      tick(4);
      chk("chip_reset", chip_reset_q, 1);
      chk("status_low", reset_status_out, 0);
      chk("cause", reset_cause_q, 4'h1 << idx);
      @(posedge ref_clk);
      {press, wdt, por, b2} <= 4'h0;
      #1;
      if (idx == 3) begin
         // supply back: pin rises while the wake count still runs
         tick(14);
         chk("status_early", reset_status_out & chip_reset_q, 1);
      end
      wait_release(idx == 3 ? 1 : WK + 1);
   endtask : t_cause

   // flash ready while the oscillator is down, then the other way round
   task automatic t_gates;
      @(posedge ref_clk);
      press <= 1;
      flash <= 1;
      osc <= 0;
      tick(4);
      @(posedge ref_clk);
      press <= 0;
      tick(40);
      chk("osc_gate", chip_reset_q, 1);
      @(posedge ref_clk);
      osc <= 1;
      flash <= 0;
      tick(20);
      chk("flash_gate", chip_reset_q, 1);
      @(posedge ref_clk);
      flash <= 1;
      wait_release(1);
   endtask : t_gates

   // second press in mid-count must start the wake count over
   task automatic t_restart;
      @(posedge ref_clk);
      press <= 1;
      tick(4);
      @(posedge ref_clk);
      press <= 0;
      tick(6);
      @(posedge ref_clk);
      press <= 1;
      tick(2);
      @(posedge ref_clk);
      press <= 0;
      wait_release(WK + 1);
   endtask : t_restart

   task automatic t_stage1(input logic en);
      @(posedge ref_clk);
      irq_en <= en;
      b1 <= 1;
      tick(4);
      chk("stage1_irq", brownout_irq_q, 1);
      chk("stage1_status", brownout_status_q, 1);
      chk("cpu_irq", cpu_irq_q, en);
      chk("irq_seen", irq_taken, en);
      chk("no_reset", chip_reset_q, 0);
      @(posedge ref_clk);
      b1 <= 0;
      tick(4);
      chk("stage1_hold", brownout_status_q, 1);
      tick(8);
      chk("stage1_clear", brownout_status_q, 0);
      chk("cpu_irq_clear", cpu_irq_q, 0);
   endtask : t_stage1

   initial begin
      // rough run is a few hundred edges; allow ample margin
      #(25 * 3000);
      n_mismatch++;
      stop_test();
   end

   initial begin
      {sys_rst, por, osc, flash} = 4'hF;
      {press, wdt, b1, b2, irq_en} = 5'h00;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 0;
      por <= 0;
      #1;
      wait_release(WK + 1);
      for (int i = 0; i < 4; i++) t_cause(i);
      t_gates();
      t_restart();
      t_stage1(1'b0);
      t_stage1(1'b1);
      stop_test();
   end
endmodule : tb_reset_brownout_control
